//--- hw/baud_consts.svh
// Function
// - high divisor byte shares a location with frame format; select bit steers writes
// - reading the high divisor byte returns the select bit as zero
// - divisor is one twelve-bit value, bits 11 down to 0
// - upper four bits from high byte, lower eight from low byte
// - writing the low byte reloads the prescaler at once
// - double speed uses divide by 8 instead of 16 in asynchronous mode; synchronous mode keeps 16
`ifndef BAUD_CONSTS_SVH
`define BAUD_CONSTS_SVH
`define OFS_DIVISOR_LOW    12'h000
`define OFS_SHARED_HIGH    12'h004
`define OFS_OPTIONS        12'h008
`define OFS_STATUS         12'h00c
`define SEL_BIT            15
`define OPT_DOUBLE_BIT     0
`define OPT_SYNC_BIT       1
`define FRAME_RESET        8'h86
`define DIV_RESET          12'h000
`define DIV_LOW_RESET      8'h00
`define DIV_HIGH_RESET     4'h0
`define RATIO_NORMAL       5'h10
`define RATIO_DOUBLE       5'h08
`endif

//--- hw/baud_pkg.sv
package baud_pkg;
    typedef logic [11:0] divisor_type;
    typedef logic [4:0]  ratio_type;
endpackage

//--- hw/baud_prescaler.sv
`timescale 1ns/1ps
`include "baud_consts.svh"
// prescaler and bit-rate divider: one tick per divisor+1 clocks, one bit per ratio ticks
module baud_prescaler (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire baud_pkg::divisor_type divisor,
    input  wire logic                 reload,
    input  wire baud_pkg::ratio_type  ratio,
    output logic                      tick_q,
    output logic                      bit_q
);
    baud_pkg::divisor_type count_q;
    baud_pkg::ratio_type   sub_q;

    // reload restarts the period at once, not at the end of the current one
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_q <= `DIV_RESET;
        end else if (reload) begin
            count_q <= divisor;
        end else if (count_q == 12'h000) begin
            count_q <= divisor;
        end else begin
            count_q <= count_q - 12'h001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= !reload && (count_q == 12'h000);
        end
    end

    // bit strobe every ratio ticks
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sub_q <= 5'h00;
            bit_q <= 1'b0;
        end else if (reload) begin
            sub_q <= 5'h00;
            bit_q <= 1'b0;
        end else if (!reload && count_q == 12'h000) begin
            if (sub_q >= ratio - 5'h01) begin
                sub_q <= 5'h00;
                bit_q <= 1'b1;
            end else begin
                sub_q <= sub_q + 5'h01;
                bit_q <= 1'b0;
            end
        end else begin
            bit_q <= 1'b0;
        end
    end
endmodule

//--- hw/baud_divisor_regs.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "baud_consts.svh"
module baud_divisor_regs (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic [11:0]      baud_divisor,
    output logic [7:0]       frame_format_control,
    output logic             double_speed,
    output logic             prescaler_reload,
    output logic             baud_tick,
    output logic             bit_tick
);
    // register state; the divisor halves are kept apart so each has one writer
    baud_pkg::divisor_type div_q;
    logic [7:0]            div_low_q;
    logic [3:0]            div_high_q;
    logic [7:0]            frame_q;
    logic                  dbl_q;
    logic                  sync_q;
    logic                  reload_q;
    logic                  setup_q;
    // prescaler strobes before their output flops
    logic                  tick_w;
    logic                  bit_w;
    // bus qualifiers and address decode
    logic                  wr_fire;
    logic                  rd_fire;
    logic                  hit_low;
    logic                  hit_high;
    logic                  hit_opts;
    logic                  hit_status;
    logic                  high_sel;
    logic [31:0]           rd_word;
    baud_pkg::ratio_type   ratio;

    // exact word match; a partial match never aliases a register
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // high location read word: divisor nibble only, select and reserved bits zero
    function automatic logic [31:0] high_word(input logic [3:0] nib);
        high_word = {16'h0000, 1'b0, 3'h0, nib, 8'h00};
    endfunction

    // answer one cycle after setup: access phase with zero wait states
    assign wr_fire = psel && penable && pready && pwrite;
    assign rd_fire = psel && !penable && !pwrite;

    // address decode shared by the write and read paths
    assign hit_low    = addr_hit(paddr, `OFS_DIVISOR_LOW);
    assign hit_high   = addr_hit(paddr, `OFS_SHARED_HIGH);
    assign hit_opts   = addr_hit(paddr, `OFS_OPTIONS);
    assign hit_status = addr_hit(paddr, `OFS_STATUS);
    // select bit of the written word picks the target at the shared location
    assign high_sel   = pwdata[`SEL_BIT];

    // ready follows a setup cycle, so it only ever rises in an access phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            setup_q <= 1'b0;
        end else begin
            setup_q <= psel && !penable;
        end
    end
    assign pready  = setup_q;
    assign pslverr = 1'b0; // no access is refused with an error

    // low divisor byte
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_low_q <= `DIV_LOW_RESET;
        end else if (wr_fire && hit_low) begin
            div_low_q <= pwdata[7:0];
        end
    end

    // high divisor nibble; reserved bits 14:12 of the write are not stored
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_high_q <= `DIV_HIGH_RESET;
        end else if (wr_fire && hit_high && !high_sel) begin
            div_high_q <= pwdata[11:8];
        end
    end

    // frame format control sits behind the same location, select bit set
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_q <= `FRAME_RESET;
        end else if (wr_fire && hit_high && high_sel) begin
            frame_q <= pwdata[7:0];
        end
    end

    // one twelve-bit divisor built from the two halves
    assign div_q = {div_high_q, div_low_q};

    // reload on every low byte write, even when the value is unchanged
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reload_q <= 1'b0;
        end else begin
            reload_q <= wr_fire && hit_low;
        end
    end

    // double speed request from the option word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dbl_q <= 1'b0;
        end else if (wr_fire && hit_opts) begin
            dbl_q <= pwdata[`OPT_DOUBLE_BIT];
        end
    end

    // synchronous mode flag; it masks the double speed request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_q <= 1'b0;
        end else if (wr_fire && hit_opts) begin
            sync_q <= pwdata[`OPT_SYNC_BIT];
        end
    end

    // double speed only counts in asynchronous mode
    assign ratio = (dbl_q && !sync_q) ? `RATIO_DOUBLE : `RATIO_NORMAL;

    // read word for the addressed location; unmapped locations read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_low) begin
            rd_word = {24'h000000, div_low_q};
        end else if (hit_high) begin
            rd_word = high_word(div_high_q);
        end else if (hit_opts) begin
            rd_word = {30'h0, sync_q, dbl_q};
        end else if (hit_status) begin
            rd_word = {12'h000, frame_q, div_q};
        end
    end

    // read data captured in setup and held through the access phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_fire) begin
            prdata <= rd_word;
        end
    end

    // divisor output, one cycle behind the register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            baud_divisor <= `DIV_RESET;
        end else begin
            baud_divisor <= div_q;
        end
    end

    // frame format output for the rest of the transceiver
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_format_control <= `FRAME_RESET;
        end else begin
            frame_format_control <= frame_q;
        end
    end

    // effective double speed, already masked by synchronous mode
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            double_speed <= 1'b0;
        end else begin
            double_speed <= dbl_q && !sync_q;
        end
    end

    // reload strobe seen outside, one cycle after the prescaler sees it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prescaler_reload <= 1'b0;
        end else begin
            prescaler_reload <= reload_q;
        end
    end

    // prescaler takes the live divisor; the reload arrives a cycle after the
    // write, so the new value is already in place when it is loaded
    baud_prescaler u_pre (
        .core_clk (core_clk),
        .rst      (rst),
        .divisor  (div_q),
        .reload   (reload_q),
        .ratio    (ratio),
        .tick_q   (tick_w),
        .bit_q    (bit_w)
    );

    // prescaler tick output
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            baud_tick <= 1'b0;
        end else begin
            baud_tick <= tick_w;
        end
    end

    // bit strobe output
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= bit_w;
        end
    end
endmodule

//--- bench/baud_regs_chk.sv
`timescale 1ns/1ps
`include "baud_consts.svh"
module baud_regs_chk (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [11:0] baud_divisor,
    input wire logic [7:0]  frame_format_control,
    input wire logic        double_speed,
    input wire logic        prescaler_reload,
    input wire logic        baud_tick,
    input wire logic        bit_tick
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // accepted transfers, qualified by ready
    logic wr;
    logic rd;
    assign wr = psel && penable && pready && pwrite;
    assign rd = psel && penable && pready && !pwrite;
    a_setup_ready: assert property (psel && !penable |=> pready) else $error("no ready");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_no_slverr: assert property (!pslverr) else $error("slave error raised");
    // register outputs trail the write edge by one flop, so look two edges on
    a_low_write: assert property (wr && paddr == `OFS_DIVISOR_LOW
        |-> ##2 baud_divisor[7:0] == $past(pwdata[7:0], 2)) else $error("low byte lost");
    a_high_write: assert property (wr && paddr == `OFS_SHARED_HIGH && !pwdata[15]
        |-> ##2 baud_divisor[11:8] == $past(pwdata[11:8], 2)) else $error("high byte lost");
    a_frame_steer: assert property (wr && paddr == `OFS_SHARED_HIGH && pwdata[15]
        |-> ##2 $stable(baud_divisor) && frame_format_control[6:0] == $past(pwdata[6:0], 2))
        else $error("select bit not honoured");
    a_select_zero: assert property (rd && paddr == `OFS_SHARED_HIGH
        |-> prdata[15:12] == 4'h0) else $error("select bit reads one");
    a_high_read: assert property (rd && paddr == `OFS_SHARED_HIGH
        |-> prdata[11:8] == baud_divisor[11:8]) else $error("high read wrong");
    a_reload: assert property (wr && paddr == `OFS_DIVISOR_LOW
        |-> ##2 prescaler_reload) else $error("no reload");
    a_double: assert property (wr && paddr == `OFS_OPTIONS
        |-> ##2 double_speed == ($past(pwdata[0], 2) && !$past(pwdata[1], 2)))
        else $error("speed");
    c_low: cover property (wr && paddr == `OFS_DIVISOR_LOW);
    c_frame: cover property (wr && paddr == `OFS_SHARED_HIGH && pwdata[15]);
    c_fast_bit: cover property (bit_tick && double_speed);
endmodule
bind baud_divisor_regs baud_regs_chk chk_u (.*);

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "baud_consts.svh"
module tb_top;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic [11:0] baud_divisor;
    logic [7:0]  frame_format_control;
    logic        pready, pslverr, double_speed, prescaler_reload, baud_tick, bit_tick;
    int          err_count = 0;
    int          tests_run = 0;
    int          gap;
    baud_divisor_regs dut_u (.*);
    // free running system clock
    initial forever #10 core_clk = ~core_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; waits on ready rather than assuming zero wait states
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // clocks between two pulses of bit_tick (sel high) or baud_tick; the first
    // interval may straddle a reload or a ratio change, so it is skipped
    task automatic pulse_gap(input logic sel, output int n);
        n = 0;
        repeat (2) begin
            @(posedge core_clk);
            while ((sel ? bit_tick : baud_tick) !== 1'b1) @(posedge core_clk);
        end
        @(posedge core_clk);
        while ((sel ? bit_tick : baud_tick) !== 1'b1) begin
            n++;
            @(posedge core_clk);
        end
        n++;
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d, comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(frame_format_control, 32'h00000086);
        apb(1'b0, `OFS_DIVISOR_LOW, 32'h0);
        check(rdat, 32'h00000000);
        apb(1'b0, `OFS_SHARED_HIGH, 32'h0);
        check(rdat, 32'h00000000);
        apb(1'b1, `OFS_DIVISOR_LOW, 32'h0000005a);
        apb(1'b1, `OFS_SHARED_HIGH, 32'h00000300);
        apb(1'b0, `OFS_SHARED_HIGH, 32'h0);
        check(rdat, 32'h00000300);
        check(baud_divisor, 32'h0000035a);
        apb(1'b1, `OFS_SHARED_HIGH, 32'h000080c6);
        // outputs trail the register by one flop
        @(posedge core_clk);
        check(frame_format_control, 32'h000000c6);
        check(baud_divisor, 32'h0000035a);
        apb(1'b1, `OFS_SHARED_HIGH, 32'h00000000);
        apb(1'b1, `OFS_DIVISOR_LOW, 32'h00000003);
        pulse_gap(1'b1, gap);
        check(gap, 32'h00000040);
        pulse_gap(1'b0, gap);
        check(gap, 32'h00000004);
        apb(1'b1, `OFS_OPTIONS, 32'h00000001);
        @(posedge core_clk);
        check(double_speed, 32'h00000001);
        pulse_gap(1'b1, gap);
        check(gap, 32'h00000020);
        apb(1'b1, `OFS_OPTIONS, 32'h00000003);
        @(posedge core_clk);
        check(double_speed, 32'h00000000);
        pulse_gap(1'b1, gap);
        check(gap, 32'h00000040);
        apb(1'b0, `OFS_OPTIONS, 32'h0);
        check(rdat, 32'h00000003);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rdat, 32'h000c6003);
        apb(1'b0, `OFS_DIVISOR_LOW, 32'h0);
        check(rdat, 32'h00000003);
        apb(1'b0, 12'h010, 32'h0);
        check(rdat, 32'h00000000);
        report_and_stop;
    end
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        err_count++;
        report_and_stop;
    end
endmodule
